// [core/udc_exec.sv]
// direct-command executor: decodes command bytes, builds air frames, keeps rn16
// ----------------------------------------
// ----------------------------------------
`include "udc_defs.svh"

module udc_exec
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// byte from the host port, pulse at last falling sclk
	input wire logic host_select_n,
	input wire logic cmd_strobe,
	input wire logic [7:0] cmd_byte,
	// fifo read side (query parameters)
	input wire logic fifo_rd_valid,
	input wire logic [7:0] fifo_rd_data,
	output logic fifo_rd_req,
	// fifo write side (received rn16)
	output logic fifo_wr_en,
	output logic [7:0] fifo_wr_data,
	// transmit setting session bits
	input wire logic [1:0] tx_session,
	// air link
	output logic tx_bit,
	output logic tx_valid,
	output logic tx_preamble,
	input wire logic rx_rn_valid,
	input wire logic [15:0] rx_rn,
	input wire logic rx_fail,
	// auxiliary controls
	input wire logic [7:0] rssi_in,
	input wire logic cal_done,
	output logic supply_auto,
	output logic vco_auto,
	output logic gain_leveling,
	output logic [7:0] rssi_held,
	output logic acs_enable,
	// status
	output logic irq_cmd,
	output logic busy
);
	import udc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	udc_state_t state_ff, nxt_state;
	logic [7:0] cmd_ff;
	logic [15:0] param_ff;
	logic pcnt_ff;
	logic [15:0] rn16_ff;
	logic [1:0] wr_cnt_ff;
	logic [7:0] wr_data_ff;
	logic irq_ff;
	logic sup_ff, vco_ff, agl_ff, acs_ff;
	logic [7:0] rssi_ff;
	logic cal_wait_ff;
	logic load;
	logic [63:0] frame;
	logic [6:0] len;
	logic sh_busy;
	logic is_direct;
	logic is_air;
	logic expect_rn;
	logic [2:0] updn;

	assign is_direct = !host_select_n && cmd_strobe &&
		({cmd_byte[`UDC_MODE_HI_BIT], cmd_byte[`UDC_MODE_LO_BIT]} == `UDC_MODE_DIRECT);
	function automatic logic air_code(input logic [7:0] c);
		air_code = (c >= `UDC_CMD_QUERY) && (c <= `UDC_CMD_REQRN);
	endfunction
	assign is_air = is_direct && air_code(cmd_byte);
	assign expect_rn = (cmd_ff != `UDC_CMD_ACK) && (cmd_ff != `UDC_CMD_NAK);

	// ----------------------------------------
	// crc-5 over a 17-bit query body
	// ----------------------------------------
	function automatic logic [4:0] crc5(input logic [16:0] d);
		logic [4:0] c;
		logic fb;
		c = `UDC_CRC5_INIT;
		for (int i = 16; i >= 0; i--) begin
			fb = d[i] ^ c[4];
			c = {c[3:0], 1'b0};
			if (fb) begin
				c = c ^ `UDC_CRC5_POLY;
			end
		end
		crc5 = c;
	endfunction

	// ----------------------------------------
	// frame builder
	// ----------------------------------------
	always_comb begin
		logic [16:0] qbody;
		qbody = {`UDC_FRM_QUERY, param_ff[15:3]};
		updn = `UDC_UPDN_NIC;
		frame = 64'h0;
		len = 7'h0;
		unique case (cmd_ff)
			`UDC_CMD_QUERY: begin
				// two leading zeros then 13 fields; lsb of the 16 is dropped
				qbody = {`UDC_FRM_QUERY, param_ff[13:1]};
				frame = {42'h0, qbody, crc5(qbody)};
				len = 7'd22;
			end
			`UDC_CMD_QREP: begin
				frame = {60'h0, `UDC_FRM_QREP, tx_session};
				len = 7'd4;
			end
			`UDC_CMD_QADJ_UP, `UDC_CMD_QADJ_NIC, `UDC_CMD_QADJ_DN: begin
				if (cmd_ff == `UDC_CMD_QADJ_UP) begin
					updn = `UDC_UPDN_UP;
				end else if (cmd_ff == `UDC_CMD_QADJ_DN) begin
					updn = `UDC_UPDN_DN;
				end
				frame = {55'h0, `UDC_FRM_QADJ, tx_session, updn};
				len = 7'd9;
			end
			`UDC_CMD_ACK: begin
				frame = {46'h0, `UDC_FRM_ACK, rn16_ff};
				len = 7'd18;
			end
			`UDC_CMD_NAK: begin
				frame = {56'h0, `UDC_FRM_NAK};
				len = 7'd8;
			end
			`UDC_CMD_REQRN: begin
				frame = {40'h0, `UDC_FRM_REQRN, rn16_ff};
				len = 7'd24;
			end
			default: begin
				frame = 64'h0;
				len = 7'h0;
			end
		endcase
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			UDC_IDLE: begin
				if (is_air) begin
					nxt_state = (cmd_byte == `UDC_CMD_QUERY) ? UDC_PARAM : UDC_SEND;
				end
			end
			UDC_PARAM: begin
				if (fifo_rd_valid && pcnt_ff) begin
					nxt_state = UDC_SEND;
				end
			end
			UDC_SEND: begin
				if (!sh_busy && !load) begin
					nxt_state = expect_rn ? UDC_WAIT_RN : UDC_DONE;
				end
			end
			UDC_WAIT_RN: begin
				if (rx_rn_valid || rx_fail) begin
					nxt_state = UDC_DONE;
				end
			end
			UDC_DONE: begin
				nxt_state = (wr_cnt_ff == 2'h0) ? UDC_IDLE : UDC_DONE;
			end
			default: nxt_state = UDC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= UDC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end
	// one load pulse on entry to send
	logic sent_ff;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sent_ff <= 1'b0;
		end else begin
			sent_ff <= (state_ff == UDC_SEND);
		end
	end
	assign load = (state_ff == UDC_SEND) && !sent_ff;

	// command latch; only taken while idle so an in-flight frame stays intact
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff <= 8'h0;
		end else if (is_air && state_ff == UDC_IDLE) begin
			cmd_ff <= cmd_byte;
		end
	end
	// query parameter bytes, first byte is the high one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			param_ff <= 16'h0;
			pcnt_ff <= 1'b0;
		end else if (state_ff == UDC_PARAM && fifo_rd_valid) begin
			param_ff <= {param_ff[7:0], fifo_rd_data};
			pcnt_ff <= !pcnt_ff;
		end else if (state_ff == UDC_IDLE) begin
			pcnt_ff <= 1'b0;
		end
	end
	assign fifo_rd_req = (state_ff == UDC_PARAM);

	// rn16 holding register: only a reply overwrites it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rn16_ff <= `UDC_RN16_RST;
		end else if (state_ff == UDC_WAIT_RN && rx_rn_valid) begin
			rn16_ff <= rx_rn;
		end
	end

	// reply copied to fifo, high byte first
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_cnt_ff <= 2'h0;
			wr_data_ff <= 8'h0;
		end else if (state_ff == UDC_WAIT_RN && rx_rn_valid) begin
			wr_cnt_ff <= 2'h2;
			wr_data_ff <= rx_rn[15:8];
		end else if (wr_cnt_ff != 2'h0) begin
			wr_cnt_ff <= wr_cnt_ff - 2'h1;
			wr_data_ff <= rn16_ff[7:0];
		end
	end
	assign fifo_wr_en = (wr_cnt_ff != 2'h0);
	assign fifo_wr_data = wr_data_ff;

	// ----------------------------------------
	// auxiliary functions
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sup_ff <= 1'b0;
			vco_ff <= 1'b0;
			cal_wait_ff <= 1'b0;
		end else begin
			if (is_direct && cmd_byte == `UDC_CMD_SUP_AUTO) begin
				sup_ff <= 1'b1;
			end else if (is_direct && cmd_byte == `UDC_CMD_SUP_MAN) begin
				sup_ff <= 1'b0;
			end
			if (is_direct && cmd_byte == `UDC_CMD_VCO_AUTO) begin
				vco_ff <= 1'b1;
			end else if (is_direct && cmd_byte == `UDC_CMD_VCO_MAN) begin
				vco_ff <= 1'b0;
			end
			// calibration starts finish later, when the analog side reports
			if (is_direct && (cmd_byte == `UDC_CMD_SUP_AUTO || cmd_byte == `UDC_CMD_VCO_AUTO)) begin
				cal_wait_ff <= 1'b1;
			end else if (cal_done) begin
				cal_wait_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			agl_ff <= 1'b0;
			acs_ff <= 1'b0;
			rssi_ff <= 8'h0;
		end else if (is_direct) begin
			unique case (cmd_byte)
				`UDC_CMD_AGL_ON: agl_ff <= 1'b1;
				`UDC_CMD_AGL_OFF: agl_ff <= 1'b0;
				`UDC_CMD_RSSI_ST: rssi_ff <= rssi_in;
				`UDC_CMD_RSSI_CLR: rssi_ff <= 8'h0;
				`UDC_CMD_ACS_ON: acs_ff <= 1'b1;
				`UDC_CMD_ACS_OFF: acs_ff <= 1'b0;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// command done
	// ----------------------------------------
	// immediate commands finish one cycle after the strobe, so the host port is never
	// held off and a chained read or write under the same select just follows
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (is_direct && !air_code(cmd_byte) && cmd_byte != `UDC_CMD_SUP_AUTO
				&& cmd_byte != `UDC_CMD_VCO_AUTO)
				|| (cal_wait_ff && cal_done)
				|| (state_ff == UDC_DONE && nxt_state == UDC_IDLE);
		end
	end

	udc_tx_shift u_shift (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.load(load),
		.frame(frame),
		.len(len),
		.tx_bit(tx_bit),
		.tx_valid(tx_valid),
		.busy(sh_busy)
	);

	assign tx_preamble = load && (cmd_ff == `UDC_CMD_QUERY);
	assign supply_auto = sup_ff;
	assign vco_auto = vco_ff;
	assign gain_leveling = agl_ff;
	assign rssi_held = rssi_ff;
	assign acs_enable = acs_ff;
	assign irq_cmd = irq_ff;
	assign busy = (state_ff != UDC_IDLE) || cal_wait_ff;

endmodule

// [core/udc_defs.svh]
// constants for the direct-command executor: codes, frame fields, timing
`ifndef UDC_DEFS_SVH
`define UDC_DEFS_SVH

// ----------------------------------------
// command byte layout
// ----------------------------------------
`define UDC_MODE_HI_BIT 7
`define UDC_MODE_LO_BIT 6
`define UDC_MODE_DIRECT 2'h2
`define UDC_ID_W 6

// ----------------------------------------
// command codes (full byte)
// ----------------------------------------
`define UDC_CMD_QUERY 8'h98
`define UDC_CMD_QREP 8'h99
`define UDC_CMD_QADJ_UP 8'h9a
`define UDC_CMD_QADJ_NIC 8'h9b
`define UDC_CMD_QADJ_DN 8'h9c
`define UDC_CMD_ACK 8'h9d
`define UDC_CMD_NAK 8'h9e
`define UDC_CMD_REQRN 8'h9f
`define UDC_CMD_SUP_AUTO 8'ha2
`define UDC_CMD_SUP_MAN 8'ha3
`define UDC_CMD_VCO_AUTO 8'ha4
`define UDC_CMD_VCO_MAN 8'ha5
`define UDC_CMD_AGL_ON 8'ha6
`define UDC_CMD_AGL_OFF 8'ha7
`define UDC_CMD_RSSI_ST 8'ha8
`define UDC_CMD_RSSI_CLR 8'ha9
`define UDC_CMD_ACS_ON 8'haa
`define UDC_CMD_ACS_OFF 8'hab

// ----------------------------------------
// air frame fields (msb first)
// ----------------------------------------
`define UDC_FRM_QUERY 4'h8
`define UDC_FRM_QREP 2'h0
`define UDC_FRM_QADJ 4'h9
`define UDC_FRM_ACK 2'h1
`define UDC_FRM_NAK 8'hc0
`define UDC_FRM_REQRN 8'hc1
`define UDC_UPDN_UP 3'h6
`define UDC_UPDN_NIC 3'h0
`define UDC_UPDN_DN 3'h3
`define UDC_CRC5_INIT 5'h09
`define UDC_CRC5_POLY 5'h09

// ----------------------------------------
// timing and reset values
// ----------------------------------------
`define UDC_CLK_MHZ 20
`define UDC_RN16_RST 16'h0000
`define UDC_FRAME_W 7'd64

`endif

// [core/udc_pkg.sv]
// types shared by the direct-command executor
package udc_pkg;

	typedef enum logic [2:0] {
		UDC_IDLE = 3'b000,
		UDC_PARAM = 3'b001,
		UDC_SEND = 3'b010,
		UDC_WAIT_RN = 3'b011,
		UDC_DONE = 3'b100
	} udc_state_t;

	typedef enum logic [1:0] {
		UDC_RN_NONE = 2'b00,
		UDC_RN_STORE = 2'b01
	} udc_rn_t;

endpackage

// [core/udc_tx_shift.sv]
// serialiser: sends the low len bits of a frame msb first, one bit per clock
`include "udc_defs.svh"

module udc_tx_shift (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// load side
	input wire logic load,
	input wire logic [63:0] frame,
	input wire logic [6:0] len,
	// air side
	output logic tx_bit,
	output logic tx_valid,
	output logic busy
);

	logic [63:0] shift_ff;
	logic [6:0] cnt_ff;
	logic bit_ff;
	logic vld_ff;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_ff <= 64'h0;
			cnt_ff <= 7'h0;
		end else if (load) begin
			// left-justify so the msb goes first
			shift_ff <= frame << (`UDC_FRAME_W - len);
			cnt_ff <= len;
		end else if (cnt_ff != 7'h0) begin
			shift_ff <= {shift_ff[62:0], 1'b0};
			cnt_ff <= cnt_ff - 7'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_ff <= 1'b0;
			vld_ff <= 1'b0;
		end else begin
			bit_ff <= shift_ff[63];
			vld_ff <= (cnt_ff != 7'h0) && !load;
		end
	end

	assign tx_bit = bit_ff;
	assign tx_valid = vld_ff;
	assign busy = (cnt_ff != 7'h0) || vld_ff;

endmodule

// [tb/udc_exec_properties.sv]
// port-level assertions for the direct-command executor
module udc_exec_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// command side
	input wire logic host_select_n,
	input wire logic cmd_strobe,
	input wire logic [7:0] cmd_byte,
	input wire logic [7:0] rssi_in,
	// watched outputs
	input wire logic supply_auto,
	input wire logic vco_auto,
	input wire logic gain_leveling,
	input wire logic [7:0] rssi_held,
	input wire logic acs_enable,
	input wire logic irq_cmd
);
	logic take;
	assign take = cmd_strobe && !host_select_n && cmd_byte[7:6] == 2'h2;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	gain_on_a: assert property (take && cmd_byte == 8'ha6 |=> gain_leveling)
		else $error("gain leveling not enabled");
	gain_off_a: assert property (take && cmd_byte == 8'ha7 |=> !gain_leveling)
		else $error("gain leveling not disabled");
	acs_on_a: assert property (take && cmd_byte == 8'haa |=> acs_enable)
		else $error("anti-collision support not enabled");
	acs_off_a: assert property (take && cmd_byte == 8'hab |=> !acs_enable)
		else $error("anti-collision support not disabled");
	rssi_store_a: assert property (take && cmd_byte == 8'ha8 |=> rssi_held == $past(rssi_in))
		else $error("rssi not latched");
	rssi_clear_a: assert property (take && cmd_byte == 8'ha9 |=> rssi_held == 8'h00)
		else $error("rssi not cleared");
	supply_manual_a: assert property (take && cmd_byte == 8'ha3 |=> !supply_auto)
		else $error("supply still automatic");
	vco_manual_a: assert property (take && cmd_byte == 8'ha5 |=> !vco_auto)
		else $error("vco still automatic");
	cmd_done_a: assert property (take && cmd_byte inside {8'ha3, [8'ha5:8'hab]} |-> ##[1:2] irq_cmd)
		else $error("no done pulse after command");
	irq_pulse_a: assert property (irq_cmd |=> !irq_cmd)
		else $error("done pulse longer than one cycle");
	mode_filter_a: assert property (cmd_strobe && cmd_byte[7:6] != 2'h2 |=>
		$stable(gain_leveling) && $stable(acs_enable) && $stable(rssi_held))
		else $error("non-direct byte acted upon");
endmodule

bind udc_exec udc_exec_properties u_props (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.host_select_n(host_select_n),
	.cmd_strobe(cmd_strobe),
	.cmd_byte(cmd_byte),
	.rssi_in(rssi_in),
	.supply_auto(supply_auto),
	.vco_auto(vco_auto),
	.gain_leveling(gain_leveling),
	.rssi_held(rssi_held),
	.acs_enable(acs_enable),
	.irq_cmd(irq_cmd)
);

// [tb/udc_host_model.sv]
// host microcontroller model: hands command bytes to the port strobe
module udc_host_model (
	// clock
	sys_clk,
	// port side
	host_select_n,
	cmd_strobe,
	cmd_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	input wire logic sys_clk;
	output logic host_select_n;
	output logic cmd_strobe;
	output logic [7:0] cmd_byte;
	initial begin
		host_select_n = 1'b1;
		cmd_strobe = 1'b0;
		cmd_byte = 8'h00;
	end
	// select stays low across commands: chained use without deselect
	task automatic send(input logic [7:0] code);
		@(negedge sys_clk);
		host_select_n = 1'b0;
		cmd_byte = code;
		cmd_strobe = 1'b1;
		@(negedge sys_clk);
		cmd_strobe = 1'b0;
		// byte no longer held once taken
		cmd_byte = ~code;
	endtask
endmodule

// [tb/uhf_reader_direct_command_exec_tb_top.sv]
// self-checking bench for the direct-command executor
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module uhf_reader_direct_command_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic host_select_n, cmd_strobe, fifo_rd_valid, fifo_rd_req, fifo_wr_en, tx_bit, tx_valid;
	logic tx_preamble, rx_rn_valid, rx_fail, cal_done, supply_auto, vco_auto, gain_leveling;
	logic acs_enable, irq_cmd, busy;
	logic [7:0] cmd_byte, fifo_rd_data, fifo_wr_data, rssi_in, rssi_held, c;
	logic [1:0] tx_session;
	logic [15:0] rx_rn, rn_held, qpar;
	logic [7:0] wq[$];
	logic [7:0] aux[8] = '{8'ha3, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hab};
	logic [7:0] airs[10] = '{8'h98, 8'h9d, 8'h9d, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9e, 8'h9f, 8'h9d};
	logic es, ev, eg, ea, fl;
	logic [7:0] er;
	int num_errors, tests_run, cyc, irqs, pre, pidx, n;
	always #25 sys_clk = ~sys_clk;
	udc_host_model host (.sys_clk(sys_clk), .host_select_n(host_select_n),
		.cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte));
	udc_exec uut (.sys_clk(sys_clk), .rst_n(rst_n), .host_select_n(host_select_n),
		.cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte), .fifo_rd_valid(fifo_rd_valid),
		.fifo_rd_data(fifo_rd_data), .fifo_rd_req(fifo_rd_req), .fifo_wr_en(fifo_wr_en),
		.fifo_wr_data(fifo_wr_data), .tx_session(tx_session), .tx_bit(tx_bit),
		.tx_valid(tx_valid), .tx_preamble(tx_preamble), .rx_rn_valid(rx_rn_valid),
		.rx_rn(rx_rn), .rx_fail(rx_fail), .rssi_in(rssi_in), .cal_done(cal_done),
		.supply_auto(supply_auto), .vco_auto(vco_auto), .gain_leveling(gain_leveling),
		.rssi_held(rssi_held), .acs_enable(acs_enable), .irq_cmd(irq_cmd), .busy(busy));
	// ----------------------------------------
	// monitors and fifo feed
	// ----------------------------------------
	always @(posedge sys_clk) begin
		cyc++;
		if (fifo_wr_en === 1'b1) wq.push_back(fifo_wr_data);
		if (tx_preamble === 1'b1) pre++;
		if (irq_cmd === 1'b1) irqs++;
		if (cyc > 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	always @(negedge sys_clk) begin
		fifo_rd_valid <= fifo_rd_req === 1'b1 && pidx < 2;
		fifo_rd_data <= pidx == 0 ? qpar[15:8] : pidx == 1 ? qpar[7:0] : 8'($urandom);
		if (fifo_rd_req === 1'b1 && pidx < 2) pidx++;
		else if (fifo_rd_req !== 1'b1) pidx = 0;
	end
	function automatic logic [4:0] crc5(input logic [16:0] d);
		logic [4:0] r;
		r = 5'h09;
		for (int i = 16; i >= 0; i--) r = {r[3:0], 1'b0} ^ ((d[i] ^ r[4]) ? 5'h09 : 5'h00);
		return r;
	endfunction
	// expected frame bits, right aligned, and their count
	function automatic int frame_of(input logic [7:0] k, output logic [31:0] f);
		case (k)
			8'h98: f = {4'h8, qpar[13:1], crc5({4'h8, qpar[13:1]})};
			8'h99: f = {2'h0, tx_session};
			8'h9a: f = {4'h9, tx_session, 3'h6};
			8'h9b: f = {4'h9, tx_session, 3'h0};
			8'h9c: f = {4'h9, tx_session, 3'h3};
			8'h9d: f = {2'h1, rn_held};
			8'h9e: f = 32'h000000c0;
			default: f = {8'hc1, rn_held};
		endcase
		return k == 8'h98 ? 22 : k == 8'h99 ? 4 : k < 8'h9d ? 9 : k == 8'h9d ? 18 : k == 8'h9e ? 8 : 24;
	endfunction
	task automatic air(input logic [7:0] k);
		logic [31:0] f;
		logic [31:0] got;
		int len;
		int i0;
		int p0;
		int w0;
		logic rep;
		rep = k inside {[8'h98:8'h9c], 8'h9f};
		len = frame_of(k, f);
		got = 32'h0;
		n = 0;
		i0 = irqs;
		p0 = pre;
		w0 = wq.size();
		host.send(k);
		for (int j = 0; j < 300; j++) begin
			@(negedge sys_clk);
			if (tx_valid === 1'b1) begin
				got = {got[30:0], tx_bit};
				n++;
			end else if (n > 0) break;
		end
		`CHK(n, len)
		`CHK(got, f)
		`CHK(pre - p0, int'(k == 8'h98))
		`CHK(busy, 1'b1)
		if (rep) begin
			@(negedge sys_clk);
			rx_rn = 16'($urandom);
			{rx_rn_valid, rx_fail} = {!fl, fl};
			@(negedge sys_clk);
			{rx_rn_valid, rx_fail} = 2'h0;
			if (!fl) rn_held = rx_rn;
			rx_rn = ~rx_rn;
		end
		for (int j = 0; j < 400 && irqs == i0; j++) @(negedge sys_clk);
		`CHK(irqs - i0, 1)
		`CHK(busy, 1'b0)
		`CHK(wq.size() - w0, rep && !fl ? 2 : 0)
		if (rep && !fl) `CHK({wq[w0], wq[w0 + 1]}, rn_held)
		@(negedge sys_clk);
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rx_rn_valid, rx_fail, cal_done, es, ev, eg, ea, fl} = 8'h00;
		{rssi_in, er, rx_rn, rn_held} = 40'h0;
		qpar = 16'($urandom(64155));
		tx_session = 2'h0;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		for (int r = 0; r < 2; r++) begin
			foreach (airs[j]) begin
				qpar = 16'($urandom) & 16'h3fff;
				tx_session = 2'($urandom);
				// one reqrn gets no reply: the following ack must resend the old value
				fl = r == 1 && j == 8;
				air(airs[j]);
			end
		end
		// calibration commands finish only on cal_done
		for (int j = 0; j < 2; j++) begin
			n = irqs;
			host.send(j ? 8'ha4 : 8'ha2);
			repeat (3) @(negedge sys_clk);
			`CHK(j ? vco_auto : supply_auto, 1'b1)
			`CHK(irqs - n, 0)
			`CHK(busy, 1'b1)
			cal_done = 1'b1;
			@(negedge sys_clk);
			cal_done = 1'b0;
			repeat (3) @(negedge sys_clk);
			`CHK(irqs - n, 1)
			`CHK(busy, 1'b0)
		end
		{es, ev} = 2'h3;
		for (int i = 0; i < 60; i++) begin
			c = aux[$urandom_range(7, 0)];
			if (i % 5 == 4) c[7] = 1'b0;
			rssi_in = 8'($urandom);
			n = irqs;
			host.send(c);
			repeat (2) @(negedge sys_clk);
			case (c)
				8'ha3: es = 1'b0;
				8'ha5: ev = 1'b0;
				8'ha6: eg = 1'b1;
				8'ha7: eg = 1'b0;
				8'ha8: er = rssi_in;
				8'ha9: er = 8'h00;
				8'haa: ea = 1'b1;
				8'hab: ea = 1'b0;
				default: ;
			endcase
			`CHK({supply_auto, vco_auto}, {es, ev})
			`CHK({gain_leveling, acs_enable}, {eg, ea})
			`CHK(rssi_held, er)
			`CHK(irqs - n, int'(c[7]))
		end
		report_and_stop();
	end
endmodule
